// ==== slc_pkg.sv ====
package slc_pkg;
    // register addresses on the four-bit select lines (octal as printed)
    localparam logic [3:0] SLC_ADDR_DATA = 4'h8;  // 10 octal
    localparam logic [3:0] SLC_ADDR_TXC = 4'h9;   // 11 octal
    localparam logic [3:0] SLC_ADDR_RXC = 4'hA;   // 12 octal
    localparam logic [3:0] SLC_ADDR_MDM = 4'hB;   // 13 octal
    localparam logic [3:0] SLC_ADDR_SYNC = 4'hC;  // 14 octal
    localparam logic [3:0] SLC_ADDR_SWA = 4'hD;   // 15 octal
    localparam logic [3:0] SLC_ADDR_SWB = 4'hE;   // 16 octal
    localparam logic [3:0] SLC_ADDR_MNT = 4'hF;   // 17 octal
    // receive control bits
    localparam int SLC_RX_CRC_OK = 0;
    localparam int SLC_RX_BLK_END = 1;
    localparam int SLC_RX_READY = 4;
    localparam int SLC_RX_LOOP = 5;
    localparam int SLC_RX_ACTIVE = 6;
    localparam int SLC_RX_CLR = 7;
    // modem control bits
    localparam int SLC_MD_HDX = 4;
    localparam int SLC_MD_DTR = 6;
    // maintenance bits
    localparam int SLC_MN_MODE = 0;
    // transmit control bits
    localparam int SLC_TX_SOM = 0;
    localparam int SLC_TX_EOM = 1;
    // crc residues for an errorless message
    localparam logic [15:0] SLC_CRC_RES_CHAR = 16'h0000;
    localparam logic [15:0] SLC_CRC_RES_BIT = 16'h1D0F; // 016417 octal
    // reset values
    localparam logic [7:0] SLC_SYNC_RST = 8'h00;
    localparam logic SLC_MODE_RST = 1'b1;
    localparam logic SLC_DTR_RST = 1'b1;
    // fifo
    localparam int SLC_FIFO_DEPTH = 32;
    localparam int SLC_FIFO_WIDTH = 12;
endpackage

// ==== slc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } slc_fifo_st_type;
    slc_fifo_st_type st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // handshakes
    assign in_ready = st_r.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_r.cnt != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[st_r.rp];

    // pointer update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            st_nxt = '0;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule // slc_fifo
`default_nettype wire

// ==== slc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_regs import slc_pkg::*; #(
    parameter bit INTEGRAL_MODEM = 1'b0,
    parameter int FIFO_DEPTH = SLC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // microprocessor buses
    input wire logic [3:0] reg_addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] obus,
    output logic [7:0] ibus,
    input wire logic mp_clear,
    // receiver side
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_char_is_crc,
    input wire logic rx_closing_flag,
    input wire logic rx_active_in,
    input wire logic [15:0] rx_crc,
    input wire logic rx_fifo_can_accept,
    output logic rx_char_ready,
    output logic rx_reset_pulse,
    output logic rx_clk_block,
    output logic internal_loopback,
    // transmitter side
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [7:0] tx_out_char,
    output logic tx_start_of_msg,
    output logic tx_end_of_msg,
    output logic tx_char_discard,
    output logic tx_wr_ready,
    input wire logic tx_crc_lsb,
    input wire logic tx_has_data,
    output logic tx_enable,
    output logic character_sync_protocol,
    // pins
    input wire logic modem_cts,
    input wire logic modem_ready,
    input wire logic modem_ring,
    input wire logic modem_serial_in,
    input wire logic rc_osc_in,
    input wire logic [1:0] switch_flags,
    input wire logic [7:0] switch_a,
    input wire logic [7:0] switch_b,
    output logic modem_rts,
    output logic modem_dtr
);
    typedef struct packed {
        logic [1:0] txc;
        logic loop;
        logic half_duplex_sel;
        logic dtr;
        logic mode;
        logic rts;
        logic rxclr;
        logic [7:0] sync;
        logic [7:0] rd_data;
        logic [23:0] s1;
        logic [23:0] s2;
    } slc_st_type;
    slc_st_type st_r, st_nxt;

    // synchronised pin view: cts,ready,ring,si,osc,sw(2),swa,swb
    logic [23:0] pins;
    assign pins = {modem_cts, modem_ready, modem_ring, modem_serial_in,
                   rc_osc_in, switch_flags, switch_a, switch_b, 1'b0};
    logic cts_s, mrdy_s, ring_s, si_s, osc_s;
    logic [1:0] swf_s;
    logic [7:0] swa_s, swb_s;
    assign {cts_s, mrdy_s, ring_s, si_s, osc_s, swf_s, swa_s, swb_s} =
        st_r.s2[23:1];

    // receive fifo holding data plus crc-match and block-end
    logic [11:0] rxf_in, rxf_out;
    logic rxf_valid, rxf_pop;
    logic crc_ok;
    always_comb begin
        if (st_r.mode) begin
            crc_ok = rx_crc == SLC_CRC_RES_CHAR;
        end else begin
            crc_ok = rx_crc == SLC_CRC_RES_BIT;
        end
    end
    // crc-match rides with the crc char; block-end with the closing flag, bit mode only
    assign rxf_in = {2'b00, rx_closing_flag && !st_r.mode,
                     crc_ok && rx_char_is_crc, rx_char};
    assign rxf_pop = rd_en && reg_addr == SLC_ADDR_DATA;

    slc_fifo #(.WIDTH(SLC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk(clk),
        .rst(rst),
        .flush(st_r.rxclr),
        .in_valid(rx_char_valid),
        .in_ready(rx_char_ready),
        .in_data(rxf_in),
        .out_valid(rxf_valid),
        .out_ready(rxf_pop),
        .out_data(rxf_out)
    );

    // transmit fifo holding data plus start and end bits
    logic txf_push;
    logic [11:0] txf_in, txf_out;
    assign txf_push = wr_en && reg_addr == SLC_ADDR_DATA;
    assign txf_in = {2'b00, st_r.txc, obus};
    slc_fifo #(.WIDTH(SLC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk(clk),
        .rst(rst),
        .flush(1'b0),
        .in_valid(txf_push),
        .in_ready(tx_wr_ready),
        .in_data(txf_in),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(txf_out)
    );
    assign tx_out_char = txf_out[7:0];
    assign tx_start_of_msg = txf_out[8];
    assign tx_end_of_msg = txf_out[9];
    // bit stuff drops characters written with start or end
    assign tx_char_discard = !st_r.mode && (txf_out[8] || txf_out[9]);

    // next state and read mux
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.rxclr = 1'b0;
        st_nxt.rts = tx_has_data && !mp_clear;
        if (txf_push) begin
            st_nxt.txc = 2'b00;
        end
        if (wr_en) begin
            case (reg_addr)
                SLC_ADDR_TXC: begin
                    st_nxt.txc = obus[1:0];
                end
                SLC_ADDR_RXC: begin
                    st_nxt.loop = obus[SLC_RX_LOOP];
                    st_nxt.rxclr = obus[SLC_RX_CLR];
                end
                SLC_ADDR_MDM: begin
                    st_nxt.half_duplex_sel = obus[SLC_MD_HDX];
                    st_nxt.dtr = obus[SLC_MD_DTR];
                end
                SLC_ADDR_SYNC: begin
                    st_nxt.sync = obus;
                end
                SLC_ADDR_MNT: begin
                    st_nxt.mode = obus[SLC_MN_MODE];
                end
                default: begin
                end
            endcase
        end
        if (mp_clear) begin
            st_nxt.half_duplex_sel = 1'b0;
            st_nxt.dtr = SLC_DTR_RST;
            st_nxt.mode = SLC_MODE_RST;
            st_nxt.txc = 2'b00;
        end
        st_nxt.rd_data = 8'h00;
        if (rd_en) begin
            case (reg_addr)
                SLC_ADDR_DATA: st_nxt.rd_data = rxf_out[7:0];
                SLC_ADDR_TXC: st_nxt.rd_data = {6'h00, st_r.txc};
                SLC_ADDR_RXC: st_nxt.rd_data = {1'b0, rx_active_in,
                    st_r.loop, rxf_valid, 2'b00,
                    rxf_out[9:8] & {2{rxf_valid}}};
                SLC_ADDR_MDM: st_nxt.rd_data = {ring_s && !INTEGRAL_MODEM,
                    st_r.dtr, st_r.rts, st_r.half_duplex_sel, mrdy_s, cts_s,
                    swf_s};
                SLC_ADDR_SYNC: st_nxt.rd_data = st_r.sync;
                SLC_ADDR_SWA: st_nxt.rd_data = swa_s;
                SLC_ADDR_SWB: st_nxt.rd_data = swb_s;
                SLC_ADDR_MNT: st_nxt.rd_data = {tx_crc_lsb, rx_crc[0],
                    si_s, tx_out_valid, rx_fifo_can_accept, 1'b0,
                    osc_s, st_r.mode};
                default: st_nxt.rd_data = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.mode <= SLC_MODE_RST;
            st_r.dtr <= SLC_DTR_RST;
            st_r.sync <= SLC_SYNC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign ibus = st_r.rd_data;
    assign rx_reset_pulse = st_r.rxclr;
    assign internal_loopback = st_r.loop;
    assign rx_clk_block = st_r.half_duplex_sel && st_r.rts;
    assign tx_enable = cts_s && mrdy_s;
    assign modem_rts = st_r.rts;
    assign modem_dtr = st_r.dtr;
    assign character_sync_protocol = st_r.mode;

    // checks
    dtr_clear_only_a: assert property (@(posedge clk) disable iff (rst)
        $fell(modem_dtr) |-> $past(wr_en) && $past(reg_addr) == SLC_ADDR_MDM
        && !$past(obus[SLC_MD_DTR]) && !$past(mp_clear))
        else $error("dtr dropped without a write of zero");
    clear_sets_a: assert property (@(posedge clk) disable iff (rst)
        mp_clear |=> character_sync_protocol && modem_dtr)
        else $error("clear did not set mode and dtr");
    hdx_clear_a: assert property (@(posedge clk) disable iff (rst)
        mp_clear |=> !rx_clk_block)
        else $error("half duplex survived clear");
    rx_reset_a: assert property (@(posedge clk) disable iff (rst)
        wr_en && reg_addr == SLC_ADDR_RXC && obus[SLC_RX_CLR]
        |=> rx_reset_pulse ##1 !rx_reset_pulse)
        else $error("receiver reset pulse wrong");
    tx_ctl_clear_a: assert property (@(posedge clk) disable iff (rst)
        txf_push && !(wr_en && reg_addr == SLC_ADDR_TXC) |=> st_r.txc == 2'b00)
        else $error("control bits not cleared by load");
    rdy_read_a: assert property (@(posedge clk) disable iff (rst)
        rd_en && reg_addr == SLC_ADDR_RXC |=> ibus[SLC_RX_READY]
        == $past(rxf_valid) && ibus[3:2] == 2'b00)
        else $error("receive ready read wrong");
    tx_en_a: assert property (@(posedge clk) disable iff (rst)
        tx_enable == (st_r.s2[23] && st_r.s2[22]))
        else $error("transmit enable mismatch");
    ring_a: assert property (@(posedge clk) disable iff (rst)
        rd_en && reg_addr == SLC_ADDR_MDM && INTEGRAL_MODEM |=> !ibus[7])
        else $error("ring not forced off");
    rts_a: assert property (@(posedge clk) disable iff (rst)
        !tx_has_data |=> !modem_rts)
        else $error("rts held with no data");
    discard_a: assert property (@(posedge clk) disable iff (rst)
        tx_char_discard |-> !character_sync_protocol)
        else $error("discard in character sync mode");
    cv_rx_read: cover property (@(posedge clk) rxf_pop && rxf_valid);
    cv_tx_load: cover property (@(posedge clk) txf_push && st_r.txc != 2'h0);
    cv_loop: cover property (@(posedge clk) internal_loopback);
endmodule // slc_regs
`default_nettype wire

// ==== slc_mp.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_mp (
    // clock
    input wire logic clk,
    // microprocessor buses
    output logic [3:0] reg_addr,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] obus,
    input wire logic [7:0] ibus
);
    // idle bus at time zero
    initial begin
        reg_addr = 4'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        obus = 8'h00;
    end
    // one write; released data lines show the inverse, not the last value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        obus <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        obus <= ~d;
    endtask
    // one read; the answer is registered and stands one cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = ibus;
    endtask
endmodule // slc_mp
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import slc_pkg::*;;
    // design side signals
    logic clk, rst, rd_en, wr_en, mp_clear;
    logic [3:0] reg_addr;
    logic [7:0] obus, ibus, rx_char, switch_a, switch_b, tx_out_char, v;
    logic rx_char_valid, rx_char_is_crc, rx_closing_flag, rx_active_in;
    logic [15:0] rx_crc;
    logic rx_fifo_can_accept, rx_char_ready, rx_reset_pulse, rx_clk_block;
    logic internal_loopback, tx_out_valid, tx_out_ready, tx_start_of_msg;
    logic tx_end_of_msg, tx_char_discard, tx_wr_ready, tx_crc_lsb;
    logic tx_has_data, tx_enable, character_sync_protocol, modem_cts;
    logic modem_ready, modem_ring, modem_serial_in, rc_osc_in;
    logic modem_rts, modem_dtr;
    logic [1:0] switch_flags;
    int n_fail, checks;
    // one register access and the value it should read back
    typedef struct packed {
        logic [3:0] a;
        logic wr;
        logic [7:0] w;
        logic [7:0] e;
    } slc_row_type;
    slc_row_type rows [15] = '{
        '{SLC_ADDR_RXC, 1'b0, 8'h00, 8'h00},
        '{SLC_ADDR_MDM, 1'b0, 8'h00, 8'hCE},
        '{SLC_ADDR_MNT, 1'b0, 8'h00, 8'hA9},
        '{SLC_ADDR_SWA, 1'b0, 8'h00, 8'hA5},
        '{SLC_ADDR_SWB, 1'b1, 8'h00, 8'h3C},
        '{SLC_ADDR_SYNC, 1'b0, 8'h00, 8'h00},
        '{SLC_ADDR_SYNC, 1'b1, 8'h5A, 8'h5A},
        '{SLC_ADDR_SYNC, 1'b1, 8'hA5, 8'hA5},
        '{SLC_ADDR_MDM, 1'b1, 8'h30, 8'h9E},
        '{SLC_ADDR_MDM, 1'b1, 8'h40, 8'hCE},
        '{SLC_ADDR_MNT, 1'b1, 8'h00, 8'hA8},
        '{SLC_ADDR_MNT, 1'b1, 8'hFE, 8'hA8},
        '{SLC_ADDR_MNT, 1'b1, 8'h01, 8'hA9},
        '{SLC_ADDR_RXC, 1'b1, 8'h2F, 8'h20},
        '{SLC_ADDR_RXC, 1'b1, 8'h00, 8'h00}};

    slc_mp mp_u (.clk, .reg_addr, .rd_en, .wr_en, .obus, .ibus);
    slc_regs dut_u (.clk, .rst, .reg_addr, .rd_en, .wr_en, .obus, .ibus,
        .mp_clear, .rx_char_valid, .rx_char, .rx_char_is_crc,
        .rx_closing_flag, .rx_active_in, .rx_crc, .rx_fifo_can_accept,
        .rx_char_ready, .rx_reset_pulse, .rx_clk_block, .internal_loopback,
        .tx_out_valid, .tx_out_ready, .tx_out_char, .tx_start_of_msg,
        .tx_end_of_msg, .tx_char_discard, .tx_wr_ready, .tx_crc_lsb,
        .tx_has_data, .tx_enable, .character_sync_protocol, .modem_cts,
        .modem_ready, .modem_ring, .modem_serial_in, .rc_osc_in,
        .switch_flags, .switch_a, .switch_b, .modem_rts, .modem_dtr);

    // 250 MHz clock
    always #2 clk = ~clk;

    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // receiver push of one character
    task automatic push(input logic [7:0] c, input logic crc, fl);
        @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char <= c;
        rx_char_is_crc <= crc;
        rx_closing_flag <= fl;
        @(posedge clk);
        rx_char_valid <= 1'b0;
    endtask
    // transmitter takes the head entry
    task automatic pop();
        @(posedge clk) tx_out_ready <= 1'b1;
        @(posedge clk) tx_out_ready <= 1'b0;
        #1;
    endtask
    // status first, then data
    task automatic rx_pair(input logic [7:0] ec, ed);
        mp_u.rd(SLC_ADDR_RXC, v);
        chk("rx_ctl", v, ec);
        mp_u.rd(SLC_ADDR_DATA, v);
        chk("rx_data", v, ed);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #10000;
        n_fail++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        n_fail = 0;
        checks = 0;
        rst <= 1'b1;
        {mp_clear, rx_char_valid, rx_char_is_crc, rx_closing_flag} <= 4'h0;
        {rx_active_in, tx_out_ready, tx_has_data, rc_osc_in} <= 4'h0;
        {rx_fifo_can_accept, tx_crc_lsb, modem_cts, modem_ready} <= 4'hF;
        {modem_ring, modem_serial_in} <= 2'h3;
        {rx_char, rx_crc} <= 24'h000000;
        {switch_flags, switch_a, switch_b} <= {2'h2, 8'hA5, 8'h3C};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_n(3);
        chk("init", {modem_dtr, modem_rts, character_sync_protocol}, 3'h5);
        chk("fifo_rdy", {rx_char_ready, tx_wr_ready}, 2'h3);
        foreach (rows[i]) begin
            if (rows[i].wr)
                mp_u.wr(rows[i].a, rows[i].w);
            mp_u.rd(rows[i].a, v);
            chk($sformatf("row%0d", i), v, rows[i].e);
        end
        mp_u.wr(SLC_ADDR_RXC, 8'h20);
        wait_n(1);
        chk("loop", internal_loopback, 1'b1);
        mp_u.wr(SLC_ADDR_RXC, 8'h00);
        // transmit control bits travel with their character
        mp_u.wr(SLC_ADDR_TXC, 8'h01);
        mp_u.wr(SLC_ADDR_DATA, 8'h55);
        mp_u.wr(SLC_ADDR_DATA, 8'h66);
        mp_u.wr(SLC_ADDR_TXC, 8'h03);
        mp_u.wr(SLC_ADDR_DATA, 8'h77);
        mp_u.rd(SLC_ADDR_MNT, v);
        chk("mnt_tx", v, 8'hB9);
        chk("tx_head", {tx_end_of_msg, tx_start_of_msg, tx_char_discard, tx_out_char}, {3'h2, 8'h55});
        mp_u.wr(SLC_ADDR_MNT, 8'h00);
        wait_n(1);
        chk("tx_head", {tx_end_of_msg, tx_start_of_msg, tx_char_discard, tx_out_char}, {3'h3, 8'h55});
        pop();
        chk("tx_head", {tx_end_of_msg, tx_start_of_msg, tx_char_discard, tx_out_char}, {3'h0, 8'h66});
        pop();
        chk("tx_head", {tx_end_of_msg, tx_start_of_msg, tx_char_discard, tx_out_char}, {3'h7, 8'h77});
        pop();
        chk("tx_empty", tx_out_valid, 1'b0);
        // receive status travels with its character
        mp_u.wr(SLC_ADDR_MNT, 8'h01);
        rx_active_in <= 1'b1;
        push(8'h31, 1'b1, 1'b0);
        push(8'h32, 1'b0, 1'b0);
        rx_pair(8'h51, 8'h31);
        rx_pair(8'h50, 8'h32);
        rx_crc <= 16'h1D0F;
        push(8'h41, 1'b1, 1'b1);
        mp_u.rd(SLC_ADDR_RXC, v);
        chk("rx_ctl", v, 8'h50);
        rx_pair(8'h50, 8'h41);
        mp_u.wr(SLC_ADDR_MNT, 8'h00);
        push(8'h42, 1'b1, 1'b1);
        rx_pair(8'h53, 8'h42);
        // receiver clear empties the receive path
        push(8'h99, 1'b0, 1'b0);
        mp_u.wr(SLC_ADDR_RXC, 8'h80);
        v = 8'h00;
        repeat (3) begin
            #1 v[0] = v[0] | rx_reset_pulse;
            @(posedge clk);
        end
        chk("rx_clr", v[0], 1'b1);
        mp_u.rd(SLC_ADDR_RXC, v);
        chk("rx_ctl", v, 8'h40);
        // modem handshake lines
        chk("tx_en", tx_enable, 1'b1);
        modem_cts <= 1'b0;
        wait_n(4);
        chk("tx_en", tx_enable, 1'b0);
        mp_u.rd(SLC_ADDR_MDM, v);
        chk("cts", v[2], 1'b0);
        modem_cts <= 1'b1;
        mp_u.wr(SLC_ADDR_MDM, 8'h10);
        tx_has_data <= 1'b1;
        wait_n(4);
        chk("hdx", {modem_rts, modem_dtr, rx_clk_block}, 3'h5);
        @(posedge clk);
        mp_clear <= 1'b1;
        tx_has_data <= 1'b0;
        @(posedge clk);
        mp_clear <= 1'b0;
        wait_n(2);
        mp_u.rd(SLC_ADDR_MDM, v);
        chk("clr", {v[5:4], character_sync_protocol, rx_clk_block}, 4'h2);
        // live pin levels in the maintenance register
        {rc_osc_in, modem_serial_in, rx_fifo_can_accept} <= 3'h4;
        {tx_crc_lsb, modem_ring} <= 2'h0;
        wait_n(4);
        mp_u.rd(SLC_ADDR_MNT, v);
        chk("mnt_pins", v, 8'h43);
        mp_u.rd(SLC_ADDR_MDM, v);
        chk("ring", v[7], 1'b0);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
